/* File: pkg/cde_pkg.sv */
// Constants and the carrier type for the opcode decode/execute block.
// Assumes a single 100 MHz core clock and a 32-bit Avalon-MM master.
package cde_pkg;
  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [7:0] REG_EXEC = 8'h00;  // W: run opcode, R: program counter
  localparam logic [7:0] REG_ACC = 8'h04;   // Accumulator
  localparam logic [7:0] REG_STAT = 8'h08;  // Status flags
  localparam logic [7:0] REG_PROD = 8'h0c;  // Product upper byte
  localparam logic [7:0] REG_DPTR = 8'h10;  // Data pointer, upper and lower
  localparam logic [7:0] REG_STACK = 8'h14; // Stack pointer
  localparam logic [7:0] REG_SPEED = 8'h18; // Core speed setting
  localparam logic [7:0] REG_FADDR = 8'h1c; // File window address
  localparam logic [7:0] REG_FDATA = 8'h20; // File window data
  localparam logic [7:0] REG_MEMOP = 8'h24; // Busy count and last memory op
  // ****************************************
  // Status layout and reset values
  // ****************************************
  localparam int ST_CARRY = 0;
  localparam int ST_NIBBLE_BORROW = 1;
  localparam int ST_ZERO = 2;
  localparam int ST_PAGE_LO = 5;
  localparam logic [7:0] ST_RW_MASK = 8'he7;  // Bits 4:3 read as zero
  localparam logic [15:0] STACK_RST = 16'h01ff;
  // ****************************************
  // Cycle counts
  // ****************************************
  localparam logic [2:0] CYC_ONE = 3'h1;
  localparam logic [2:0] CYC_SKIP = 3'h2;
  localparam logic [2:0] CYC_BRANCH = 3'h3;
  localparam logic [2:0] CYC_PROG = 3'h4;
  // ****************************************
  // Opcode fields
  // ****************************************
  localparam logic [15:0] OP_RET = 16'h0007;
  localparam logic [15:0] OP_FERASE = 16'h0003;
  localparam logic [15:0] OP_IWRITE = 16'h0018;
  localparam logic [15:0] OP_IREAD = 16'h0019;
  localparam logic [15:0] OP_FWRITE = 16'h001a;
  localparam logic [15:0] OP_FREAD = 16'h001b;
  localparam logic [12:0] OP_PAGE = 13'h0002;  // Upper 13 bits of page opcode
  localparam logic [7:0] OP_SPEED = 8'h01;
  localparam logic [7:0] L_LOADH = 8'h70;
  localparam logic [7:0] L_LOADL = 8'h71;
  localparam logic [7:0] L_MULU = 8'h72;
  localparam logic [7:0] L_MULS = 8'h73;
  localparam logic [7:0] L_PUSH = 8'h74;
  localparam logic [7:0] L_RETW = 8'h78;
  localparam logic [7:0] L_SUB = 8'h7a;
  localparam logic [7:0] L_MOVW = 8'h7c;
  localparam logic [5:0] K_MOVF = 6'h00;   // Move acc to file, dest bit set
  localparam logic [5:0] K_SUB = 6'h02;
  localparam logic [5:0] K_DEC = 6'h03;
  localparam logic [5:0] K_MOVW = 6'h08;   // Dest bit set means test
  localparam logic [5:0] K_INC = 6'h0a;
  localparam logic [5:0] K_DECSZ = 6'h0b;
  localparam logic [5:0] K_RR = 6'h0c;
  localparam logic [5:0] K_RL = 6'h0d;
  localparam logic [5:0] K_SWAP = 6'h0e;
  localparam logic [5:0] K_INCSZ = 6'h0f;
  localparam logic [5:0] K_STK = 6'h11;    // Push, or pop with dest bit set
  localparam logic [5:0] K_SUBC = 6'h12;
  localparam logic [5:0] K_DECSNZ = 6'h13;
  localparam logic [5:0] K_MULU = 6'h14;
  localparam logic [5:0] K_MULS = 6'h15;
  localparam logic [5:0] K_INCSNZ = 6'h16;
  localparam logic [3:0] B_CLR = 4'h8;
  localparam logic [3:0] B_SET = 4'h9;
  localparam logic [3:0] B_SKIPCLR = 4'ha;
  localparam logic [3:0] B_SKIPSET = 4'hb;
  localparam logic [2:0] BR_CALL = 3'h6;   // Top three opcode bits of a call
  localparam logic [2:0] BR_JMP = 3'h7;    // Top three opcode bits of a jump
  // Memory operation pulse positions
  localparam int MO_FREAD = 0;
  localparam int MO_FWRITE = 1;
  localparam int MO_FERASE = 2;
  localparam int MO_IREAD = 3;
  localparam int MO_IWRITE = 4;
  // ****************************************
  // Carrier
  // ****************************************
  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] address;
    logic [31:0] writedata;
  } cde_av_req_t;
endpackage

/* File: core/cde_core.sv */
// Decode and execute of one opcode per bus write, with its state.
// Assumes an Avalon-MM master honouring waitrequest; one clock.
`timescale 1ns/10ps
module cde_core #(
  parameter int FILE_DEPTH = 512,
  parameter int CALL_DEPTH = 16
) (
  input wire logic core_clk,                  // Core clock
  input wire logic rst,                       // Sync reset, high
  input wire cde_pkg::cde_av_req_t av_req,    // Avalon request
  output logic [31:0] av_readdata,            // Avalon read data
  output logic av_waitrequest,                // Avalon stall
  output logic [7:0] core_speed,              // Speed setting
  output logic [4:0] mem_op_go                // Memory op pulses
);
  import cde_pkg::*;

  // ****************************************
  // Storage and state
  // ****************************************
  logic [7:0] file_mem [FILE_DEPTH];          // File registers
  logic [15:0] call_mem [CALL_DEPTH];         // Return addresses
  logic [$clog2(CALL_DEPTH)-1:0] csp_ff;      // Next free call slot
  logic [7:0] acc_ff;
  logic [7:0] status_ff;
  logic [7:0] product_upper_byte_ff;
  logic [7:0] pointer_upper_byte_ff;
  logic [7:0] pointer_lower_byte_ff;
  logic [15:0] stack_pointer_ff;
  logic [7:0] speed_ff;
  logic [15:0] pc_ff;
  logic [8:0] faddr_ff;                       // File window address
  logic [2:0] busy_ff;                        // Cycles still owed
  logic rd_ok_ff;                             // Read data is ready
  logic [31:0] rdata_ff;
  logic [4:0] memop_ff;                       // Pulse out
  logic [4:0] last_op_ff;                     // Last op, for readback

  // ****************************************
  // Decode signals
  // ****************************************
  logic [15:0] ins;
  logic [5:0] key;
  logic to_file;                              // Destination is the file
  logic [8:0] fa;
  logic [7:0] file_operand;
  logic [7:0] immediate_byte;
  logic [15:0] stack_up;
  logic [7:0] pop_val;
  logic [15:0] call_top;
  logic go;
  logic bus_wr;
  logic [7:0] nxt_acc;
  logic [7:0] nxt_status;
  logic [7:0] nxt_product_upper_byte;
  logic [7:0] nxt_pointer_upper_byte;
  logic [7:0] nxt_pointer_lower_byte;
  logic [15:0] nxt_stack_pointer;
  logic [7:0] nxt_speed;
  logic [15:0] nxt_pc;
  logic f_we;
  logic [8:0] f_wa;
  logic [7:0] f_wd;
  logic [7:0] res;
  logic put;
  logic skip;
  logic [2:0] cyc;
  logic cs_push;
  logic cs_pop;
  logic [4:0] op_go;
  logic [9:0] sub_r;
  logic [15:0] prod;

  assign ins = av_req.writedata[15:0];
  assign key = ins[15:10];
  assign to_file = ins[9];
  assign fa = ins[8:0];
  assign file_operand = file_mem[fa];
  assign immediate_byte = ins[7:0];
  assign stack_up = stack_pointer_ff + 16'h0001;
  assign pop_val = file_mem[stack_up[8:0]];
  assign call_top = call_mem[csp_ff - 1'b1];
  assign bus_wr = av_req.write && !av_waitrequest;
  assign go = bus_wr && av_req.address == REG_EXEC;

  // Subtract b from a with carry-in; returns {C, DC, result}
  function automatic logic [9:0] sub8(input logic [7:0] a, input logic [7:0] b,
                                      input logic cin);
    logic [8:0] s9;
    logic [4:0] s5;
    s9 = {1'b0, a} + {1'b0, ~b} + {8'h00, cin};
    s5 = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, cin};
    return {s9[8], s5[4], s9[7:0]};
  endfunction

  // ****************************************
  // Execute decode
  // ****************************************
  always_comb begin
    nxt_acc = acc_ff;
    nxt_status = status_ff;
    nxt_product_upper_byte = product_upper_byte_ff;
    nxt_pointer_upper_byte = pointer_upper_byte_ff;
    nxt_pointer_lower_byte = pointer_lower_byte_ff;
    nxt_stack_pointer = stack_pointer_ff;
    nxt_speed = speed_ff;
    nxt_pc = pc_ff + 16'h0001;
    f_we = 1'b0;
    f_wa = fa;
    f_wd = file_operand;
    res = file_operand;
    put = 1'b0;
    skip = 1'b0;
    cyc = CYC_ONE;
    cs_push = 1'b0;
    cs_pop = 1'b0;
    op_go = 5'h00;
    sub_r = sub8(file_operand, acc_ff, 1'b1);
    prod = 16'(acc_ff) * 16'(file_operand);
    if (ins[15:13] == BR_CALL || ins[15:13] == BR_JMP) begin
      // Paged branch; call saves the next address. Bit ops share bit 15, so three bits decide
      nxt_pc = {status_ff[7:5], ins[12:0]};
      cyc = CYC_BRANCH;
      cs_push = ins[15:13] == BR_CALL;
    end else if (ins[15:14] == 2'b10) begin
      // Bit clear, set and skip tests; flags untouched
      unique case (ins[15:12])
        B_CLR: begin
          f_we = 1'b1;
          f_wd[ins[11:9]] = 1'b0;
        end
        B_SET: begin
          f_we = 1'b1;
          f_wd[ins[11:9]] = 1'b1;
        end
        B_SKIPCLR: skip = !file_operand[ins[11:9]];
        default: skip = file_operand[ins[11:9]];
      endcase
    end else if (ins[15:12] == 4'h7) begin
      // Immediate forms
      unique case (ins[15:8])
        L_LOADH: nxt_pointer_upper_byte = immediate_byte;
        L_LOADL: nxt_pointer_lower_byte = immediate_byte;
        L_MULU: begin
          prod = 16'(acc_ff) * 16'(immediate_byte);
          {nxt_product_upper_byte, nxt_acc} = prod;
        end
        L_MULS: begin
          prod = 16'($signed(acc_ff)) * 16'($signed(immediate_byte));
          {nxt_product_upper_byte, nxt_acc} = prod;
        end
        L_PUSH: begin
          f_we = 1'b1;
          f_wa = stack_pointer_ff[8:0];
          f_wd = immediate_byte;
          nxt_stack_pointer = stack_pointer_ff - 16'h0001;
        end
        L_RETW: begin
          nxt_acc = immediate_byte;
          nxt_pc = call_top;
          nxt_status[7:5] = call_top[15:13];
          cs_pop = 1'b1;
          cyc = CYC_BRANCH;
        end
        L_SUB: begin
          sub_r = sub8(immediate_byte, acc_ff, 1'b1);
          nxt_acc = sub_r[7:0];
          nxt_status[ST_CARRY] = sub_r[9];
          nxt_status[ST_NIBBLE_BORROW] = sub_r[8];
          nxt_status[ST_ZERO] = sub_r[7:0] == 8'h00;
        end
        L_MOVW: nxt_acc = immediate_byte;
        default: ;  // Out-of-scope immediates act as no-ops
      endcase
    end else if (ins[15:8] == OP_SPEED) begin
      nxt_speed = immediate_byte;
    end else if (ins[15:8] == 8'h00) begin
      // System opcodes
      if (ins[15:3] == OP_PAGE) begin
        nxt_status[7:5] = ins[2:0];
      end else begin
        unique case (ins)
          OP_RET: begin
            nxt_pc = call_top;
            nxt_status[7:5] = call_top[15:13];
            cs_pop = 1'b1;
            cyc = CYC_BRANCH;
          end
          OP_FREAD: op_go[MO_FREAD] = 1'b1;
          OP_FWRITE: op_go[MO_FWRITE] = 1'b1;
          OP_FERASE: op_go[MO_FERASE] = 1'b1;
          OP_IREAD: begin
            op_go[MO_IREAD] = 1'b1;
            cyc = CYC_PROG;
          end
          OP_IWRITE: begin
            op_go[MO_IWRITE] = 1'b1;
            cyc = CYC_PROG;
          end
          default: ;  // Nop and unsupported system codes
        endcase
      end
    end else begin
      // File-operand forms; put sends res to file or acc
      unique case (key)
        K_MOVF: begin
          f_we = 1'b1;
          f_wd = acc_ff;
        end
        K_MOVW: begin
          nxt_status[ST_ZERO] = file_operand == 8'h00;
          if (!to_file) nxt_acc = file_operand;
        end
        K_INC, K_DEC: begin
          res = key == K_INC ? file_operand + 8'h01 : file_operand - 8'h01;
          put = 1'b1;
          nxt_status[ST_ZERO] = res == 8'h00;
        end
        K_DECSZ, K_DECSNZ: begin
          res = file_operand - 8'h01;
          put = 1'b1;
          skip = (res == 8'h00) == (key == K_DECSZ);
        end
        K_INCSZ, K_INCSNZ: begin
          res = file_operand + 8'h01;
          put = 1'b1;
          skip = (res == 8'h00) == (key == K_INCSZ);
        end
        K_MULU: {nxt_product_upper_byte, nxt_acc} = prod;
        K_MULS: begin
          prod = 16'($signed(acc_ff)) * 16'($signed(file_operand));
          {nxt_product_upper_byte, nxt_acc} = prod;
        end
        K_RL: begin
          res = {file_operand[6:0], status_ff[ST_CARRY]};
          nxt_status[ST_CARRY] = file_operand[7];
          put = 1'b1;
        end
        K_RR: begin
          res = {status_ff[ST_CARRY], file_operand[7:1]};
          nxt_status[ST_CARRY] = file_operand[0];
          put = 1'b1;
        end
        K_SUB, K_SUBC: begin
          if (key == K_SUBC) sub_r = sub8(file_operand, acc_ff, status_ff[ST_CARRY]);
          res = sub_r[7:0];
          put = 1'b1;
          nxt_status[ST_CARRY] = sub_r[9];
          nxt_status[ST_NIBBLE_BORROW] = sub_r[8];
          nxt_status[ST_ZERO] = sub_r[7:0] == 8'h00;
        end
        K_SWAP: begin
          res = {file_operand[3:0], file_operand[7:4]};
          put = 1'b1;
        end
        K_STK: begin
          f_we = 1'b1;
          if (to_file) begin
            nxt_stack_pointer = stack_up;
            f_wd = pop_val;
          end else begin
            f_wa = stack_pointer_ff[8:0];
            nxt_stack_pointer = stack_pointer_ff - 16'h0001;
          end
        end
        default: ;  // Logical, add and compare are not handled here
      endcase
    end
    if (put) begin
      if (to_file) begin
        f_we = 1'b1;
        f_wd = res;
      end else begin
        nxt_acc = res;
      end
    end
    if (skip) begin
      nxt_pc = pc_ff + 16'h0002;
      cyc = CYC_SKIP;
    end
  end

  // ****************************************
  // Bus slave
  // ****************************************
  // Reads stall one cycle; opcodes stall while a prior one runs
  always_comb begin
    if (av_req.read) av_waitrequest = !rd_ok_ff;
    else av_waitrequest = av_req.write && av_req.address == REG_EXEC && busy_ff != 3'h0;
  end
  assign av_readdata = rdata_ff;

  // Read capture
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rd_ok_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
    end else begin
      rd_ok_ff <= av_req.read && !rd_ok_ff;
      if (av_req.read && !rd_ok_ff) begin
        unique case (av_req.address)
          REG_EXEC: rdata_ff <= {16'h0000, pc_ff};
          REG_ACC: rdata_ff <= {24'h000000, acc_ff};
          REG_STAT: rdata_ff <= {24'h000000, status_ff & ST_RW_MASK};
          REG_PROD: rdata_ff <= {24'h000000, product_upper_byte_ff};
          REG_DPTR: rdata_ff <= {16'h0000, pointer_upper_byte_ff, pointer_lower_byte_ff};
          REG_STACK: rdata_ff <= {16'h0000, stack_pointer_ff};
          REG_SPEED: rdata_ff <= {24'h000000, speed_ff};
          REG_FADDR: rdata_ff <= {23'h000000, faddr_ff};
          REG_FDATA: rdata_ff <= {24'h000000, file_mem[faddr_ff]};
          REG_MEMOP: rdata_ff <= {21'h000000, busy_ff, 3'h0, last_op_ff};
          default: rdata_ff <= 32'h0000_0000;  // Unmapped reads as zero
        endcase
      end
    end
  end

  // ****************************************
  // Core registers
  // ****************************************
  // Executed opcode wins; otherwise software writes
  always_ff @(posedge core_clk) begin
    if (rst) begin
      acc_ff <= 8'h00;
      status_ff <= 8'h00;
      product_upper_byte_ff <= 8'h00;
      pointer_upper_byte_ff <= 8'h00;
      pointer_lower_byte_ff <= 8'h00;
      stack_pointer_ff <= STACK_RST;
      speed_ff <= 8'h00;
      pc_ff <= 16'h0000;
      faddr_ff <= 9'h000;
    end else if (go) begin
      acc_ff <= nxt_acc;
      status_ff <= nxt_status;
      product_upper_byte_ff <= nxt_product_upper_byte;
      pointer_upper_byte_ff <= nxt_pointer_upper_byte;
      pointer_lower_byte_ff <= nxt_pointer_lower_byte;
      stack_pointer_ff <= nxt_stack_pointer;
      speed_ff <= nxt_speed;
      pc_ff <= nxt_pc;
    end else if (bus_wr) begin
      unique case (av_req.address)
        REG_ACC: acc_ff <= av_req.writedata[7:0];
        REG_STAT: status_ff <= av_req.writedata[7:0] & ST_RW_MASK;
        REG_STACK: stack_pointer_ff <= av_req.writedata[15:0];
        REG_FADDR: faddr_ff <= av_req.writedata[8:0];
        default: ;  // Read-only, unmapped, or REG_FDATA (written in the file memory block)
      endcase
    end
  end

  // File memory and call stack writes
  always_ff @(posedge core_clk) begin
    if (go && f_we) file_mem[f_wa] <= f_wd;
    else if (bus_wr && av_req.address == REG_FDATA) file_mem[faddr_ff] <= av_req.writedata[7:0];
    if (go && cs_push) call_mem[csp_ff] <= pc_ff + 16'h0001;
  end

  // Call stack pointer
  always_ff @(posedge core_clk) begin
    if (rst) csp_ff <= '0;
    else if (go && cs_push) csp_ff <= csp_ff + 1'b1;
    else if (go && cs_pop) csp_ff <= csp_ff - 1'b1;
  end

  // Cycle owing and memory op pulses
  always_ff @(posedge core_clk) begin
    if (rst) begin
      busy_ff <= 3'h0;
      memop_ff <= 5'h00;
      last_op_ff <= 5'h00;
    end else begin
      busy_ff <= go ? cyc - CYC_ONE : (busy_ff != 3'h0 ? busy_ff - 3'h1 : 3'h0);
      memop_ff <= go ? op_go : 5'h00;
      if (go && op_go != 5'h00) last_op_ff <= op_go;
    end
  end
  assign mem_op_go = memop_ff;
  assign core_speed = speed_ff;

  // ****************************************
  // Checks
  // ****************************************
  inc_acc_a: assert property (@(posedge core_clk) disable iff (rst)
    go && key == K_INC && !to_file |=> acc_ff == 8'($past(file_operand) + 8'h01)
    && status_ff[1:0] == $past(status_ff[1:0])) else $error("inc into acc wrong");
  dec_skip_a: assert property (@(posedge core_clk) disable iff (rst)
    go && key == K_DECSNZ && file_operand != 8'h01 |=> pc_ff == $past(pc_ff) + 16'h0002
    && status_ff == $past(status_ff)) else $error("decsnz skip wrong");
  inc_skip_a: assert property (@(posedge core_clk) disable iff (rst)
    go && key == K_INCSZ && file_operand == 8'hff |=> busy_ff == 3'h1 ##1 busy_ff == 3'h0)
    else $error("incsz skip cycles wrong");
  mul_sign_a: assert property (@(posedge core_clk) disable iff (rst)
    go && key == K_MULS |=> {product_upper_byte_ff, acc_ff} ==
    16'($signed($past(acc_ff))) * 16'($signed($past(file_operand)))) else $error("muls wrong");
  mul_uns_a: assert property (@(posedge core_clk) disable iff (rst)
    go && ins[15:8] == L_MULU |=> {product_upper_byte_ff, acc_ff} ==
    16'($past(acc_ff)) * 16'($past(immediate_byte))) else $error("mulu wrong");
  rot_right_a: assert property (@(posedge core_clk) disable iff (rst)
    go && key == K_RR && !to_file |=> acc_ff == {$past(status_ff[0]), $past(file_operand[7:1])}
    && status_ff[0] == $past(file_operand[0])) else $error("rr wrong");
  sub_lit_a: assert property (@(posedge core_clk) disable iff (rst)
    go && ins[15:8] == L_SUB |=> acc_ff == 8'($past(immediate_byte) - $past(acc_ff))
    && status_ff[0] == ($past(immediate_byte) >= $past(acc_ff))) else $error("sub wrong");
  ret_cycles_a: assert property (@(posedge core_clk) disable iff (rst)
    go && ins == OP_RET |=> busy_ff == 3'h2 ##1 busy_ff == 3'h1 ##1 busy_ff == 3'h0)
    else $error("ret cycles wrong");
  page_load_a: assert property (@(posedge core_clk) disable iff (rst)
    go && ins[15:3] == OP_PAGE |=> status_ff[7:5] == $past(ins[2:0]))
    else $error("page bits wrong");
  prog_op_a: assert property (@(posedge core_clk) disable iff (rst)
    go && ins == OP_IREAD |=> mem_op_go[MO_IREAD] && busy_ff == 3'h3 ##3 busy_ff == 3'h0)
    else $error("iread timing wrong");
endmodule  // cde_core

/* File: tb/cde_mem_model.sv */
// Stand-in for the program and flash memory behind the memory op pulses.
// Assumes one-cycle pulses on the core clock; counts each started op.
`timescale 1ns/10ps
module cde_mem_model (
  input wire logic core_clk,        // Core clock
  input wire logic rst,             // Sync reset, high
  input wire logic [4:0] mem_op_go, // Memory op pulses
  output logic [7:0] op_count_ff    // Ops started so far
);
  // Each pulse starts one flash or program memory operation
  always_ff @(posedge core_clk) begin
    if (rst) begin
      op_count_ff <= 8'h00;
    end else if (mem_op_go != 5'h00) begin
      op_count_ff <= op_count_ff + 8'h01;
    end
  end
endmodule // cde_mem_model

/* File: tb/testbench.sv */
// Self-checking bench for the opcode decode/execute block.
// Assumes cde_core behind an Avalon-MM slave port on a 100 MHz clock.
`timescale 1ns/10ps
module testbench;
  import cde_pkg::*;
  // File, acc, status, opcode, then expected acc, file, status, product
  typedef struct packed {
    logic [7:0] f, a, s;
    logic [15:0] op;
    logic [7:0] ea, ef, es, ep;
  } cde_row_t;
  logic core_clk;     // Core clock
  logic rst;          // Sync reset
  cde_av_req_t req;   // Bus request
  logic [31:0] rdata; // Read data
  logic wait_rq;      // Bus stall
  logic [7:0] speed;  // Speed setting
  logic [4:0] go;     // Memory op pulses
  logic [7:0] n_ops;  // Ops seen by memory model
  logic [31:0] q;     // Last word read
  realtime t_acc;     // Time of last accept
  realtime t_prev;    // Time of accept before
  int miscompares = 0;
  int comparisons = 0;
  int cycles = 0;
  cde_row_t rows[14] = '{
    '{8'hff, 8'h55, 8'h00, 16'h2810, 8'h00, 8'hff, 8'h04, 8'h00},
    '{8'h01, 8'h77, 8'h03, 16'h0c10, 8'h00, 8'h01, 8'h07, 8'h00},
    '{8'h10, 8'h01, 8'he0, 16'h0810, 8'h0f, 8'h10, 8'he1, 8'h00},
    '{8'h05, 8'h05, 8'h00, 16'h4a10, 8'h05, 8'hff, 8'h00, 8'h00},
    '{8'h01, 8'h00, 8'h05, 16'h3410, 8'h03, 8'h01, 8'h04, 8'h00},
    '{8'h01, 8'h22, 8'h00, 16'h3210, 8'h22, 8'h00, 8'h01, 8'h00},
    '{8'h5a, 8'h00, 8'h07, 16'h3810, 8'ha5, 8'h5a, 8'h07, 8'h00},
    '{8'h00, 8'h33, 8'h00, 16'h2210, 8'h33, 8'h00, 8'h04, 8'h00},
    '{8'h00, 8'h11, 8'h00, 16'h9e10, 8'h11, 8'h80, 8'h00, 8'h00},
    '{8'hff, 8'h11, 8'h02, 16'h8010, 8'h11, 8'hfe, 8'h02, 8'h00},
    '{8'h00, 8'hff, 8'h00, 16'h72ff, 8'h01, 8'h00, 8'h00, 8'hfe},
    '{8'h02, 8'h00, 8'h07, 16'h4e10, 8'h00, 8'h01, 8'h07, 8'hfe},
    '{8'hff, 8'h02, 8'h01, 16'h5410, 8'hfe, 8'hff, 8'h01, 8'hff},
    '{8'h00, 8'hff, 8'h00, 16'h73ff, 8'h01, 8'h00, 8'h00, 8'h00}};
  logic [15:0] chain[8] = '{16'h3e10, 16'h0019, 16'hc100, 16'h0007,
    16'h0000, 16'h001b, 16'h001a, 16'h0003};
  int gaps[7] = '{2, 4, 3, 3, 1, 1, 1};
  cde_core dut (.core_clk(core_clk), .rst(rst), .av_req(req), .av_readdata(rdata),
    .av_waitrequest(wait_rq), .core_speed(speed), .mem_op_go(go));
  cde_mem_model mem (.core_clk(core_clk), .rst(rst), .mem_op_go(go), .op_count_ff(n_ops));
  // Clock generator
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // One bus cycle: raised after an edge, held until waitrequest is seen low at a rising edge
  task automatic bus(input logic r, input logic [7:0] a, input logic [31:0] d);
    req <= '{read: r, write: !r, address: a, writedata: d};
    @(posedge core_clk);
    while (wait_rq !== 1'b0) @(posedge core_clk);
    q = rdata;
    t_acc = $realtime;
  endtask
  // Compare seen against expected
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", n, exp, seen);
    end
  endtask
  // Verdict and end of run
  task automatic conclude;
    $display("Comparisons %0d, mismatches %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Hang guard
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      conclude();
    end
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rst = 1'b1;
    req = '0;
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    bus(1, REG_STACK, 0);
    chk("stack reset", q, 32'h1ff);
    bus(1, 8'h3c, 0);
    chk("unmapped", q, 32'h0);
    $display("reset test done");
    foreach (rows[i]) begin
      bus(0, REG_FADDR, 32'h10);
      bus(0, REG_FDATA, {24'h0, rows[i].f});
      bus(0, REG_ACC, {24'h0, rows[i].a});
      bus(0, REG_STAT, {24'h0, rows[i].s});
      bus(0, REG_EXEC, {16'h0, rows[i].op});
      bus(1, REG_ACC, 0);
      chk("acc", q, {24'h0, rows[i].ea});
      bus(1, REG_FDATA, 0);
      chk("file", q, {24'h0, rows[i].ef});
      bus(1, REG_STAT, 0);
      chk("status", q, {24'h0, rows[i].es});
      bus(1, REG_PROD, 0);
      chk("product", q, {24'h0, rows[i].ep});
      $display("row %0d done", i);
    end
    bus(0, REG_EXEC, 32'h743c);
    bus(1, REG_STACK, 0);
    chk("push pointer", q, 32'h1fe);
    bus(0, REG_EXEC, 32'h4610);
    bus(1, REG_STACK, 0);
    chk("pop pointer", q, 32'h1ff);
    bus(1, REG_FDATA, 0);
    chk("pop data", q, 32'h3c);
    bus(0, REG_EXEC, 32'h7012);
    bus(0, REG_EXEC, 32'h7134);
    bus(1, REG_DPTR, 0);
    chk("pointer", q, 32'h1234);
    bus(0, REG_EXEC, 32'h0015);
    bus(0, REG_EXEC, 32'h01a5);
    bus(1, REG_STAT, 0);
    chk("page", q & 32'he0, 32'ha0);
    chk("speed", {24'h0, speed}, 32'ha5);
    $display("stack and pointer test done");
    bus(0, REG_FDATA, 32'hff);
    foreach (chain[i]) begin
      t_prev = t_acc;
      bus(0, REG_EXEC, {16'h0, chain[i]});
      if (i > 0) chk("cycles", int'((t_acc - t_prev) / 10.0), gaps[i-1]);
    end
    req <= '0;
    repeat (3) @(posedge core_clk);
    chk("memory ops", {24'h0, n_ops}, 32'h4);
    bus(1, REG_MEMOP, 0);
    chk("last op", q, 32'h4);
    $display("timing test done");
    req <= '0;
    rst <= 1'b1;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    chk("speed reset", {24'h0, speed}, 32'h0);
    bus(1, REG_STACK, 0);
    chk("stack after reset", q, 32'h1ff);
    bus(1, REG_STAT, 0);
    chk("status after reset", q, 32'h0);
    $display("mid-run reset test done");
    conclude();
  end
endmodule // testbench
